// >>> design/intc_pkg.sv
// Constants, register map and field layout of the two-level interrupt unit.
package intc_pkg;
  localparam int NUM_SRC = 6;
  localparam int SRC_W = 3;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 16;
  // Source indices in fixed polling order.
  localparam logic [SRC_W-1:0] SRC_EXT0 = 3'h0;
  localparam logic [SRC_W-1:0] SRC_TMR0 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_TMR1 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_UART = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TMR2 = 3'h5;
  // Vector table: base plus fixed spacing per source.
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TMR_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TMR2_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  // Reset values.
  localparam logic [NUM_SRC-1:0] RST_ENABLE = 6'h00;
  localparam logic [NUM_SRC-1:0] RST_LEVEL = 6'h00;
  // Timer control register fields.
  localparam int TC_EXT0_EDGE = 0;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT1_EDGE = 2;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_TMR0_FLAG = 4;
  localparam int TC_TMR1_FLAG = 5;
  // Timer 2 control register fields.
  localparam int T2_EXT_EN = 0;
  localparam int T2_EXT_FLAG = 1;
  // Status register fields.
  localparam int ST_LOW_BUSY = 0;
  localparam int ST_HIGH_BUSY = 1;
  localparam int ST_CALL_PEND = 2;
  localparam int ST_SRC_LSB = 8;
  // Machine cycle timing in system clocks.
  localparam int CLOCKS_PER_CYCLE = 12;
  localparam int SAMPLE_SLOT = 9;
  typedef enum logic [0:0] {
    CALL_IDLE = 1'b0,
    CALL_WAIT = 1'b1
  } call_state_t;
endpackage

// >>> design/machine_cycle_timer.sv
// Machine cycle divider giving the sample phase and the cycle end strobes.
`timescale 1ns/10ps
module machine_cycle_timer #(
  parameter int CYCLE_CLOCKS = intc_pkg::CLOCKS_PER_CYCLE,
  parameter int SAMPLE_AT = intc_pkg::SAMPLE_SLOT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic samplePulse,
  output logic cycleEnd
);
  import intc_pkg::*;
  localparam int CNT_W = $clog2(CYCLE_CLOCKS);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLE_CLOCKS - 1);
  localparam logic [CNT_W-1:0] SAMPLE = CNT_W'(SAMPLE_AT);

  if (CYCLE_CLOCKS < 3 || SAMPLE_AT >= CYCLE_CLOCKS - 1) begin : g_check
    $error("Sample slot must fall before the last clock of a machine cycle.");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic sample;
    logic last;
  } timer_t;

  timer_t s;
  timer_t next_s;

  always_comb begin
    next_s = s;
    next_s.count = (s.count == LAST) ? '0 : s.count + 1'b1;
    next_s.sample = (next_s.count == SAMPLE);
    next_s.last = (next_s.count == LAST);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign samplePulse = s.sample;
  assign cycleEnd = s.last;
endmodule

// >>> design/ext_pin_detector.sv
// Samples one external request pin once per machine cycle and keeps its flag.
`timescale 1ns/10ps
module ext_pin_detector (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic samplePulse,
  input wire logic pinIn,
  input wire logic edgeMode,
  input wire logic detectEnable,
  input wire logic clearReq,
  output logic flag
);
  typedef struct packed {
    logic prevSample;
    logic flag;
  } detect_t;

  detect_t s;
  detect_t next_s;

  always_comb begin
    next_s = s;
    if (edgeMode && clearReq) begin
      next_s.flag = 1'b0; // R12
    end
    if (samplePulse) begin
      next_s.prevSample = pinIn;
      if (!edgeMode) begin
        next_s.flag = detectEnable && !pinIn; // R15
      end else if (detectEnable && s.prevSample && !pinIn) begin
        next_s.flag = 1'b1; // R16
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '{prevSample: 1'b1, flag: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign flag = s.flag;
endmodule

// >>> design/two_level_vectored_interrupt_unit.sv
// Two-level vectored interrupt unit with APB registers and a core call handshake.
// Functional notes
// R1: Per-source level bit, one means high.
// R2: Low routine preempted only by high requests.
// R3: High routine is never preempted.
// R4: High level wins over low level.
// R5: Fixed order inside a level.
// R6: Sample flags each cycle, poll next cycle.
// R7: Block call on busy level, non-final, exit, write.
// R8: One instruction runs after exit or write.
// R9: Blocked requests are not remembered.
// R10: Hardware long call, no status word saved.
// R11: Fixed vectors eight bytes apart.
// R12: Edge-mode external flag cleared when vectored.
// R13: Exit instruction ends current in-progress level.
// R14: Plain return keeps the in-progress state.
// R15: Level mode requests on sampled low.
// R16: Edge mode sets flag on high-low samples.
// R17: Level source holds request, releases before exit.
// R18: Timer 2 pin falling edge sets flag if enabled.
// R19: Source holds pin levels long enough.
// R20: Edge source holds high then low cycles.
// R21: Serial and timer 2 flags left to software.
// R22: Timer 0 and 1 flags cleared when vectored.
// R23: Per-source enable gates vectoring.
// R24: Core handshake: final cycle, type, call acknowledge.
`timescale 1ns/10ps
module two_level_vectored_interrupt_unit #(
  parameter int CYCLE_CLOCKS = intc_pkg::CLOCKS_PER_CYCLE,
  parameter int SAMPLE_AT = intc_pkg::SAMPLE_SLOT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [intc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext0IrqPin,
  input wire logic ext1IrqPin,
  input wire logic tmr2ExtPin,
  input wire logic tmr0Overflow,
  input wire logic tmr1Overflow,
  input wire logic tmr2OverflowFlag,
  input wire logic rxDoneFlag,
  input wire logic txDoneFlag,
  input wire logic lastCycle,
  input wire logic isrExitInstr,
  input wire logic intRegWriteInstr,
  input wire logic callAck,
  output logic callReq,
  output logic [intc_pkg::VEC_W-1:0] callVector
);
  import intc_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] level;
    logic ext0Edge;
    logic ext1Edge;
    logic t2ExtEn;
    logic t0Flag;
    logic t1Flag;
    logic [NUM_SRC-1:0] sampled;
    logic [1:0] inProg;
    logic holdOff;
    call_state_t st;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] vector;
    logic callReq;
    logic ext0Clr;
    logic ext1Clr;
    logic t2Clr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } unit_t;

  unit_t s;
  unit_t next_s;
  logic samplePulse;
  logic cycleEnd;
  logic ext0Flag;
  logic ext1Flag;
  logic t2ExtFlag;
  logic [NUM_SRC-1:0] rawFlags;
  logic [NUM_SRC-1:0] pendHigh;
  logic [NUM_SRC-1:0] pendLow;

  // Returns the index of the first set bit in polling order.
  function automatic logic [SRC_W-1:0] first_src(input logic [NUM_SRC-1:0] m);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction

  // Vector address of a source index.
  function automatic logic [VEC_W-1:0] vec_of(input logic [SRC_W-1:0] idx);
    return VEC_BASE + VEC_W'(VEC_STEP * idx); // R11
  endfunction

  // True for the two registers whose writes hold off vectoring.
  function automatic logic is_int_reg(input logic [ADDR_W-1:0] addr);
    return addr == OFS_ENABLE || addr == OFS_LEVEL;
  endfunction

  // True for an address that answers without an error.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr, input logic write);
    return is_int_reg(addr) || addr == OFS_TMR_CTRL || addr == OFS_TMR2_CTRL ||
      (addr == OFS_STATUS && !write);
  endfunction

  // The divider needs a sample slot before the last clock of a machine cycle.
  if (CYCLE_CLOCKS < 3 || SAMPLE_AT < 0 || SAMPLE_AT >= CYCLE_CLOCKS - 1) begin : g_param_check
    $error("Machine cycle parameters out of range.");
  end

  machine_cycle_timer #(
    .CYCLE_CLOCKS(CYCLE_CLOCKS),
    .SAMPLE_AT(SAMPLE_AT)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .samplePulse(samplePulse),
    .cycleEnd(cycleEnd)
  );

  ext_pin_detector u_ext0 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .samplePulse(samplePulse),
    .pinIn(ext0IrqPin),
    .edgeMode(s.ext0Edge),
    .detectEnable(1'b1),
    .clearReq(s.ext0Clr),
    .flag(ext0Flag)
  );

  ext_pin_detector u_ext1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .samplePulse(samplePulse),
    .pinIn(ext1IrqPin),
    .edgeMode(s.ext1Edge),
    .detectEnable(1'b1),
    .clearReq(s.ext1Clr),
    .flag(ext1Flag)
  );

  // The timer 2 pin is always edge detected and gated by its enable.
  ext_pin_detector u_tmr2 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .samplePulse(samplePulse),
    .pinIn(tmr2ExtPin),
    .edgeMode(1'b1),
    .detectEnable(s.t2ExtEn), // R18
    .clearReq(s.t2Clr),
    .flag(t2ExtFlag)
  );

  // Serial and timer 2 requests are ORed from both of their flags.
  always_comb begin
    rawFlags = '0;
    rawFlags[SRC_EXT0] = ext0Flag;
    rawFlags[SRC_TMR0] = s.t0Flag;
    rawFlags[SRC_EXT1] = ext1Flag;
    rawFlags[SRC_TMR1] = s.t1Flag;
    rawFlags[SRC_UART] = rxDoneFlag | txDoneFlag;
    rawFlags[SRC_TMR2] = tmr2OverflowFlag | t2ExtFlag;
    pendHigh = s.sampled & s.level; // R1
    pendLow = s.sampled & ~s.level;
  end

  always_comb begin
    logic commit;
    logic wr;
    logic intRegWr;
    logic instrBlock;
    logic [31:0] rd;
    commit = psel && penable && s.pready;
    wr = commit && pwrite;
    intRegWr = wr && is_int_reg(paddr);
    instrBlock = !lastCycle || isrExitInstr || intRegWriteInstr || s.holdOff; // R7
    rd = '0;
    next_s = s;
    next_s.ext0Clr = 1'b0;
    next_s.ext1Clr = 1'b0;
    next_s.t2Clr = 1'b0;

    // Timer overflow flags.
    if (tmr0Overflow) begin
      next_s.t0Flag = 1'b1;
    end
    if (tmr1Overflow) begin
      next_s.t1Flag = 1'b1;
    end

    // Flags are captured at the sample phase and polled at the cycle end.
    if (samplePulse) begin
      next_s.sampled = rawFlags & s.enable; // R6 R23
    end

    // Polling and vectoring.
    unique case (s.st)
      CALL_IDLE: begin
        if (cycleEnd) begin
          if (lastCycle) begin
            next_s.holdOff = 1'b0; // R8
          end
          // Only the exit instruction ends a level; a plain return leaves it busy.
          if (isrExitInstr && lastCycle) begin // R14
            if (s.inProg[1]) begin
              next_s.inProg[1] = 1'b0; // R13
            end else begin
              next_s.inProg[0] = 1'b0; // R13
            end
          end
          // Only the current sample is looked at, nothing is queued.
          if (!instrBlock) begin // R9
            if (|pendHigh && !s.inProg[1]) begin // R3 R4
              next_s.src = first_src(pendHigh); // R5
              next_s.vector = vec_of(first_src(pendHigh));
              next_s.callReq = 1'b1;
              next_s.st = CALL_WAIT;
            end else if (|pendLow && s.inProg == 2'b00) begin // R2
              next_s.src = first_src(pendLow); // R5
              next_s.vector = vec_of(first_src(pendLow));
              next_s.callReq = 1'b1;
              next_s.st = CALL_WAIT;
            end
          end
        end
      end
      CALL_WAIT: begin
        // The core runs the long call, pushing only the program counter.
        if (callAck) begin // R10 R24
          next_s.callReq = 1'b0;
          next_s.st = CALL_IDLE;
          next_s.inProg[s.level[s.src]] = 1'b1;
          next_s.ext0Clr = (s.src == SRC_EXT0); // R12
          next_s.ext1Clr = (s.src == SRC_EXT1); // R12
          // A new overflow in the acknowledge cycle keeps its flag set.
          if (s.src == SRC_TMR0 && !tmr0Overflow) begin
            next_s.t0Flag = 1'b0; // R22
          end
          if (s.src == SRC_TMR1 && !tmr1Overflow) begin
            next_s.t1Flag = 1'b0; // R22
          end
        end
      end
    endcase

    // A write to the enable or level register blocks one more instruction.
    if (intRegWr) begin
      next_s.holdOff = 1'b1; // R8
    end

    // Register writes; flags use write-one-to-clear and a new set wins.
    if (wr) begin
      unique case (paddr)
        OFS_ENABLE: next_s.enable = pwdata[NUM_SRC-1:0];
        OFS_LEVEL: next_s.level = pwdata[NUM_SRC-1:0]; // R1
        OFS_TMR_CTRL: begin
          next_s.ext0Edge = pwdata[TC_EXT0_EDGE];
          next_s.ext1Edge = pwdata[TC_EXT1_EDGE];
          next_s.ext0Clr = next_s.ext0Clr | pwdata[TC_EXT0_FLAG];
          next_s.ext1Clr = next_s.ext1Clr | pwdata[TC_EXT1_FLAG];
          if (pwdata[TC_TMR0_FLAG] && !tmr0Overflow) begin
            next_s.t0Flag = 1'b0;
          end
          if (pwdata[TC_TMR1_FLAG] && !tmr1Overflow) begin
            next_s.t1Flag = 1'b0;
          end
        end
        OFS_TMR2_CTRL: begin
          next_s.t2ExtEn = pwdata[T2_EXT_EN];
          next_s.t2Clr = pwdata[T2_EXT_FLAG]; // R21
        end
        default: ;
      endcase
    end

    // Read data and error answer, presented with pready.
    unique case (paddr)
      OFS_ENABLE: rd[NUM_SRC-1:0] = s.enable;
      OFS_LEVEL: rd[NUM_SRC-1:0] = s.level;
      OFS_TMR_CTRL: begin
        rd[TC_EXT0_EDGE] = s.ext0Edge;
        rd[TC_EXT0_FLAG] = ext0Flag;
        rd[TC_EXT1_EDGE] = s.ext1Edge;
        rd[TC_EXT1_FLAG] = ext1Flag;
        rd[TC_TMR0_FLAG] = s.t0Flag;
        rd[TC_TMR1_FLAG] = s.t1Flag;
      end
      OFS_TMR2_CTRL: begin
        rd[T2_EXT_EN] = s.t2ExtEn;
        rd[T2_EXT_FLAG] = t2ExtFlag;
      end
      OFS_STATUS: begin
        rd[ST_LOW_BUSY] = s.inProg[0];
        rd[ST_HIGH_BUSY] = s.inProg[1]; // R14
        rd[ST_CALL_PEND] = s.callReq;
        rd[ST_SRC_LSB +: SRC_W] = s.src;
      end
      default: rd = '0;
    endcase
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      next_s.pslverr = !is_mapped(paddr, pwrite);
    end else begin
      next_s.pslverr = 1'b0;
    end
  end

  // Reset leaves every source disabled and both levels idle.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.enable <= RST_ENABLE;
      s.level <= RST_LEVEL;
      s.st <= CALL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign callReq = s.callReq;
  assign callVector = s.vector; // R24
endmodule

// >>> bench/intc_assertions.sv
// Port checker for the interrupt unit's register bus and core call handshake.
`timescale 1ns/10ps
module intc_assertions #(
  parameter int CYCLE_CLOCKS = 12,
  parameter int SAMPLE_AT = 9
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lastCycle,
  input wire logic isrExitInstr,
  input wire logic intRegWriteInstr,
  input wire logic callAck,
  input wire logic callReq,
  input wire logic [intc_pkg::VEC_W-1:0] callVector
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait state");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  AST_CALL_HOLD: assert property (callReq && !callAck |=> callReq)
    else $error("call dropped before acknowledge");
  AST_CALL_DROP: assert property (callReq && callAck |=> !callReq)
    else $error("call held after acknowledge");
  AST_VEC_HOLD: assert property (callReq |=> $stable(callVector))
    else $error("vector moved during call");
  AST_VEC_TABLE: assert property (callReq |-> callVector inside {16'h0003, 16'h000b,
    16'h0013, 16'h001b, 16'h0023, 16'h002b}) else $error("vector off table");
  AST_FINAL_ONLY: assert property ($rose(callReq) |-> $past(lastCycle))
    else $error("call outside final cycle");
  AST_EXIT_WRITE: assert property ($rose(callReq) |-> !$past(isrExitInstr) &&
    !$past(intRegWriteInstr)) else $error("call after exit or register write");
endmodule
bind two_level_vectored_interrupt_unit intc_assertions #(.CYCLE_CLOCKS(CYCLE_CLOCKS),
  .SAMPLE_AT(SAMPLE_AT)) chk (.sys_clk, .reset_n, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .lastCycle, .isrExitInstr, .intRegWriteInstr, .callAck, .callReq, .callVector);

// >>> bench/core_model.sv
// Behavioural core that takes each hardware call after a set delay.
`timescale 1ns/10ps
module core_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic callReq,
  input wire logic [3:0] ackDelay,
  output logic callAck
);
  logic ackReg = 1'b0;
  logic [3:0] waitCount = 4'h0;
  assign callAck = ackReg;
  always @(posedge sys_clk) begin
    if (!reset_n || !callReq || ackReg) begin
      ackReg <= 1'b0;
      waitCount <= 4'h0;
    end else if (waitCount >= ackDelay) begin
      ackReg <= 1'b1;
    end else begin
      waitCount <= waitCount + 4'h1;
    end
  end
endmodule

// >>> bench/two_level_vectored_interrupt_unit_tb.sv
// Self-checking bench for the two-level vectored interrupt unit.
`timescale 1ns/10ps
module two_level_vectored_interrupt_unit_tb;
  import intc_pkg::*;
  localparam int CYC = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext0IrqPin = 1'b1;
  logic ext1IrqPin = 1'b1;
  logic tmr2ExtPin = 1'b1;
  logic tmr0Overflow = 1'b0;
  logic tmr1Overflow = 1'b0;
  logic tmr2OverflowFlag = 1'b0;
  logic rxDoneFlag = 1'b0;
  logic txDoneFlag = 1'b0;
  logic lastCycle = 1'b1;
  logic isrExitInstr = 1'b0;
  logic intRegWriteInstr = 1'b0;
  logic callAck;
  logic callReq;
  logic [VEC_W-1:0] callVector;
  logic [3:0] ackDelay = 4'h0;
  int fails = 0;
  int checked = 0;
  two_level_vectored_interrupt_unit #(.CYCLE_CLOCKS(CYC), .SAMPLE_AT(1)) uut (.sys_clk,
    .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext0IrqPin, .ext1IrqPin, .tmr2ExtPin, .tmr0Overflow, .tmr1Overflow,
    .tmr2OverflowFlag, .rxDoneFlag, .txDoneFlag, .lastCycle, .isrExitInstr,
    .intRegWriteInstr, .callAck, .callReq, .callVector);
  core_model partner (.sys_clk, .reset_n, .callReq, .ackDelay, .callAck);
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
      input logic [31:0] expRd, input logic expErr);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (!wr) check("prdata", expRd, prdata);
    check("ready", {30'h0, 1'b1, expErr}, {30'h0, pready, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expectCall(input logic [VEC_W-1:0] vec);
    int n;
    n = 0;
    while (callReq !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check("callVector", {15'h0, 1'b1, vec}, {15'h0, callReq, callVector});
    while (callReq === 1'b1 && n < 80) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic expectNone(input int len);
    logic seen;
    seen = 1'b0;
    repeat (len) begin
      @(posedge sys_clk);
      if (callReq !== 1'b0) seen = 1'b1;
    end
    check("noCall", 32'h0, {31'h0, seen});
  endtask
  task automatic retire();
    repeat (2 * CYC) @(posedge sys_clk);
    isrExitInstr <= 1'b1;
    repeat (CYC) @(posedge sys_clk);
    isrExitInstr <= 1'b0;
  endtask
  task automatic regsAtReset();
    apb(1'b0, OFS_ENABLE, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_LEVEL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_TMR_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h7, 32'h0, 1'b1);
  endtask
  task automatic pollOrder();
    apb(1'b1, OFS_ENABLE, 32'h3f, 32'h0, 1'b0);
    tmr0Overflow <= 1'b1;
    tmr1Overflow <= 1'b1;
    @(posedge sys_clk);
    tmr0Overflow <= 1'b0;
    tmr1Overflow <= 1'b0;
    rxDoneFlag <= 1'b1;
    expectCall(16'h000b);
    apb(1'b0, OFS_TMR_CTRL, 32'h0, 32'h20, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0101, 1'b0);
    expectNone(20);
    retire();
    expectCall(16'h001b);
    apb(1'b0, OFS_TMR_CTRL, 32'h0, 32'h0, 1'b0);
    retire();
    expectCall(16'h0023);
    rxDoneFlag <= 1'b0;
    retire();
  endtask
  task automatic nesting();
    apb(1'b1, OFS_LEVEL, 32'h04, 32'h0, 1'b0);
    apb(1'b1, OFS_TMR_CTRL, 32'h04, 32'h0, 1'b0);
    ackDelay <= 4'h6;
    tmr2OverflowFlag <= 1'b1;
    expectCall(16'h002b);
    ext1IrqPin <= 1'b0;
    expectCall(16'h0013);
    ext1IrqPin <= 1'b1;
    apb(1'b0, OFS_TMR_CTRL, 32'h0, 32'h04, 1'b0);
    ext0IrqPin <= 1'b0;
    expectNone(20);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0203, 1'b0);
    retire();
    expectNone(20);
    retire();
    expectCall(16'h0003);
    ext0IrqPin <= 1'b1;
    retire();
    expectCall(16'h002b);
    tmr2OverflowFlag <= 1'b0;
    retire();
  endtask
  task automatic blocking();
    apb(1'b1, OFS_ENABLE, 32'h2f, 32'h0, 1'b0);
    txDoneFlag <= 1'b1;
    expectNone(20);
    lastCycle <= 1'b0;
    apb(1'b1, OFS_ENABLE, 32'h3f, 32'h0, 1'b0);
    expectNone(20);
    txDoneFlag <= 1'b0;
    repeat (2 * CYC) @(posedge sys_clk);
    lastCycle <= 1'b1;
    expectNone(20);
    intRegWriteInstr <= 1'b1;
    txDoneFlag <= 1'b1;
    expectNone(20);
    intRegWriteInstr <= 1'b0;
    expectCall(16'h0023);
    txDoneFlag <= 1'b0;
    retire();
    apb(1'b1, OFS_TMR2_CTRL, 32'h1, 32'h0, 1'b0);
    tmr2ExtPin <= 1'b0;
    expectCall(16'h002b);
    apb(1'b0, OFS_TMR2_CTRL, 32'h0, 32'h3, 1'b0);
    apb(1'b1, OFS_TMR2_CTRL, 32'h2, 32'h0, 1'b0);
    retire();
  endtask
  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    regsAtReset();
    pollOrder();
    nesting();
    blocking();
    print_verdict();
  end
endmodule
